// *** bench/cmam_core_bench.sv ***
// Self-checking bench for the mask, mailbox and timer block.
// Inputs change on falling edges; cmam_cpu owns the SFR port.
`timescale 1ns/1ps
`default_nettype none
module cmam_core_bench;
  import cmam_pkg::*;
  typedef struct {logic [7:0] a, d, e;} cmam_row_s;
  localparam cmam_ident_t ID = {8'h12, 8'h34, 8'h56, 5'h0a};
  cmam_row_s rows [10] = '{'{8'ha1, 8'h5a, 8'h5a}, '{8'hbc, 8'h12, 8'h12},
    '{8'hbd, 8'h34, 8'h34}, '{8'hbe, 8'h56, 8'h56}, '{8'hbf, 8'h50, 8'h50},
    '{8'hc4, 8'hff, 8'hff}, '{8'hc5, 8'hff, 8'hff}, '{8'hc6, 8'hff, 8'hff},
    '{8'hc7, 8'hfd, 8'hfd}, '{8'h00, 8'h77, 8'h00}};
  logic clock = 1'b0, rst = 1'b1, page_load = 1'b0, auto_inc_en = 1'b1;
  logic rx_check = 1'b0, rx_ext = 1'b0, rx_rtr = 1'b0, obj_rx_en = 1'b1;
  logic obj_ext = 1'b1, mbox_wr = 1'b0, timer_clk_tick = 1'b0;
  logic sfr_wr, sfr_rd, rx_hit;
  logic [7:0] sfr_addr, sfr_rdata;
  cmam_byte_t sfr_wdata, mbox_wdata = 8'h3c;
  logic [3:0] page_obj = 4'h3, mbox_wobj = 4'h3;
  logic [2:0] page_index = 3'h6, mbox_windex = 3'h2;
  cmam_ident_t rx_ident = ID;
  logic [15:0] message_timer_count;
  int err_count = 0, checked = 0;
  cmam_core u_cmam_core (.clock, .rst, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .page_obj, .page_index, .page_load,
    .auto_inc_en, .rx_check, .rx_ext, .rx_ident, .rx_rtr, .obj_rx_en,
    .obj_ext, .rx_hit, .mbox_wr, .mbox_wobj, .mbox_windex, .mbox_wdata,
    .timer_clk_tick, .message_timer_count);
  cmam_cpu u_cmam_cpu (.clock, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata);
  always #12.5 clock = ~clock;
  task automatic check(input string nm, logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic w(input logic [7:0] a, cmam_byte_t d);
    u_cmam_cpu.acc(1'b1, a, d);
  endtask
  task automatic r(input logic [7:0] a);
    u_cmam_cpu.acc(1'b0, a, 8'h00);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  task automatic hit(input logic rr, x, e, cmam_ident_t id, logic exp);
    rx_rtr = rr;
    rx_ext = x;
    obj_rx_en = e;
    rx_ident = id;
    pulse(rx_check);
    check("hit", rx_hit, exp);
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    // Tag and mask hold nothing after reset, so each is set before use
    foreach (rows[i]) begin
      w(rows[i].a, rows[i].d);
      r(rows[i].a);
      check("reg", sfr_rdata, rows[i].e);
    end
    hit(0, 1, 1, ID, 1);
    hit(1, 1, 1, ID, 0);
    hit(0, 0, 1, ID, 0);
    hit(0, 1, 1, ID ^ 29'h1, 0);
    hit(0, 1, 0, ID, 0);
    w(8'hc7, 8'h04);
    hit(0, 1, 1, ID ^ 29'h1f, 1);
    hit(0, 0, 1, ID, 1);
    hit(1, 1, 1, ID, 0);
    w(8'hc4, 8'h00);
    hit(0, 1, 1, ID ^ 29'h1fe00000, 1);
    obj_ext = 1'b0;
    w(8'hc4, 8'hff);
    w(8'hc5, 8'he0);
    hit(0, 0, 1, 29'h091, 1);
    hit(0, 0, 1, 29'h090, 0);
    // Three bytes from index 6 cross the wrap at 7
    pulse(page_load);
    for (int i = 0; i < 3; i++) w(8'ha3, cmam_byte_t'(8'ha0 + i));
    pulse(page_load);
    for (int i = 0; i < 3; i++) begin
      r(8'ha3);
      check("mbox", sfr_rdata, 16'(8'ha0 + i));
    end
    page_index = 3'h7;
    pulse(page_load);
    check("page", sfr_rdata, 8'ha1);
    pulse(mbox_wr);
    page_index = 3'h2;
    pulse(page_load);
    r(8'ha3);
    check("fill", sfr_rdata, 8'h3c);
    w(8'ha1, 8'h00);
    repeat (3) pulse(timer_clk_tick);
    r(8'hac);
    check("tim", sfr_rdata, 8'h03);
    w(8'ha1, 8'h01);
    repeat (4) pulse(timer_clk_tick);
    r(8'had);
    check("timh", sfr_rdata, 8'h00);
    check("tim", message_timer_count, 16'h0005);
    rst = 1'b1;
    @(negedge clock);
    check("rst", message_timer_count, 16'h0000);
    rst = 1'b0;
    complete_run();
  end
  // Sequence takes some 120 cycles; allow ample margin
  initial begin
    #20000;
    err_count++;
    complete_run();
  end
endmodule // cmam_core_bench
`default_nettype wire

// *** bench/cmam_core_monitor.sv ***
// Port checker for the mask, mailbox and timer block.
// Bound to cmam_core; one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cmam_core_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire cmam_pkg::cmam_byte_t sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic rx_check,
  input wire logic obj_rx_en,
  input wire logic rx_hit,
  input wire logic timer_clk_tick,
  input wire logic [15:0] message_timer_count
);
  import cmam_pkg::*;
  logic [7:0] presc_q;
  logic [7:0] presc_d;
  // Shadow prescaler: only divide-by-one has a phase-free step rule
  always_comb begin
    presc_d = presc_q;
    if (sfr_wr && sfr_addr == 8'ha1) presc_d = sfr_wdata;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) presc_q <= 8'h00;
    else presc_q <= presc_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_RST_CLEAR: assert property (
    $fell(rst) |-> message_timer_count == 16'h0000 && !rx_hit)
    else $error("reset value wrong");
  AST_HIT_CAUSE: assert property (
    rx_hit |-> $past(rx_check) && $past(obj_rx_en))
    else $error("hit without enabled check");
  AST_NO_HIT_IDLE: assert property (
    !rx_check |=> !rx_hit)
    else $error("hit without check");
  AST_UNMAPPED: assert property (
    $past(sfr_addr) == 8'h00 |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_TIMER_HOLD: assert property (
    !timer_clk_tick |=> $stable(message_timer_count))
    else $error("timer moved without tick");
  AST_TIMER_STEP: assert property (
    !$stable(message_timer_count) |->
    message_timer_count == 16'($past(message_timer_count) + 16'h0001))
    else $error("timer step not one");
  AST_PRESC_ONE: assert property (
    timer_clk_tick && presc_q == 8'h00 |=>
    message_timer_count == 16'($past(message_timer_count) + 16'h0001))
    else $error("undivided tick missed");
  AST_REG_BACK: assert property (
    sfr_wr && sfr_addr inside {8'ha1, [8'hbc:8'hbf], [8'hc4:8'hc7]}
    ##1 !sfr_wr && $stable(sfr_addr) |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("register read back wrong");
endmodule // cmam_core_monitor
bind cmam_core cmam_core_monitor u_cmam_core_monitor (.clock, .rst,
  .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .rx_check, .obj_rx_en,
  .rx_hit, .timer_clk_tick, .message_timer_count);
`default_nettype wire

// *** bench/cmam_cpu.sv ***
// Core-side model: drives the SFR strobes off falling edges.
// Assumes one calling process; one access per call.
`timescale 1ns/1ps
`default_nettype none
module cmam_cpu (
  input wire logic clock,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output cmam_pkg::cmam_byte_t sfr_wdata
);
  import cmam_pkg::*;
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // Address held after use; data inverted so stale bytes never pass
  task automatic acc(input logic w, logic [7:0] a, cmam_byte_t d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge clock);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = ~d;
  endtask
endmodule // cmam_cpu
`default_nettype wire

// *** hw/cmam_core.sv ***
// Mask filter, mailbox data window and message timer prescaler.
// Assumes a single-cycle SFR port from the core on the same clock and
// a page pointer held elsewhere that selects object and byte index.
`timescale 1ns/1ps
`default_nettype none
`include "cmam_defs.svh"

module cmam_core #(
  parameter int NUM_OBJ = 15
) (
  input wire logic clock,
  input wire logic rst,
  // SFR port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire cmam_pkg::cmam_byte_t sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Page pointer from the page register
  input wire logic [3:0] page_obj,
  input wire logic [2:0] page_index,
  input wire logic page_load,
  input wire logic auto_inc_en,
  // Receive filter inputs
  input wire logic rx_check,
  input wire logic rx_ext,
  input wire cmam_pkg::cmam_ident_t rx_ident,
  input wire logic rx_rtr,
  input wire logic obj_rx_en,
  input wire logic obj_ext,
  output logic rx_hit,
  // Mailbox fill from the receive engine
  input wire logic mbox_wr,
  input wire logic [3:0] mbox_wobj,
  input wire logic [2:0] mbox_windex,
  input wire cmam_pkg::cmam_byte_t mbox_wdata,
  // Timer tick source and count
  input wire logic timer_clk_tick,
  output logic [15:0] message_timer_count
);
  import cmam_pkg::*;

  // Register map seen by the core, all bytes on one 8-bit SFR port:
  //   a1       timer prescale value, read and write
  //   a3       mailbox data window of the selected object
  //   ac, ad   message timer low and high byte, read only
  //   bc..bf   identifier tag bytes one to four
  //   c4..c7   acceptance mask bytes one to four
  // Every other address reads as zero and ignores writes.
  //
  // Timing of the port:
  //   A strobe is taken at the rising edge together with the address.
  //   Read data is registered, so it shows the byte of the address
  //   presented one cycle earlier and then follows the address.
  //   Back-to-back accesses are allowed; nothing is queued.
  //
  // Tag and mask bytes keep whatever software last wrote, reserved
  // bits included. Software must not set reserved bits, and what it
  // reads back from them carries no meaning. Keeping them as plain
  // storage costs a few flops but keeps the read mux uniform.
  //
  // Only one set of tag and mask bytes is held: it belongs to the
  // object that the page pointer selects. Swapping objects is the
  // job of the page logic outside this block.
  //
  // Limitation: the timer high and low bytes are read independently,
  // with no latch between them. Software reading a running timer must
  // read twice or stop the tick source to get a coherent value.
  //
  // Limitation: page_obj values beyond NUM_OBJ-1 address no storage
  // and must not be used by the page logic.

  // Tag and mask bytes of the selected object; no reset on purpose
  cmam_byte_t tag_q [4];
  cmam_byte_t tag_d [4];
  cmam_byte_t mask_q [4];
  cmam_byte_t mask_d [4];
  // Mailbox storage, one byte per object and index
  cmam_byte_t mbox_q [NUM_OBJ*8];
  cmam_byte_t mbox_d [NUM_OBJ*8];
  logic [2:0] idx_q, idx_d;
  cmam_byte_t presc_q, presc_d;
  cmam_byte_t pcnt_q, pcnt_d;
  logic [15:0] timer_q, timer_d;
  logic hit_q, hit_d;
  logic [7:0] rdata_q, rdata_d;

  // Flat mailbox address of an object and byte index
  function automatic int unsigned mbox_addr(input logic [3:0] obj,
                                            input logic [2:0] idx);
    mbox_addr = int'(obj) * 8 + int'(idx);
  endfunction

  // Masked compare of one bit: zero forces a match
  function automatic logic bit_ok(input logic m, input logic t,
                                  input logic r);
    bit_ok = !m || (t == r);
  endfunction

  // Tag and mask registers: plain storage, software initialises them
  always_comb begin
    tag_d = tag_q;
    mask_d = mask_q;
    if (sfr_wr) begin
      if (sfr_addr == `CMAM_ADDR_IDT1) begin
        tag_d[0] = sfr_wdata;
      end else if (sfr_addr == `CMAM_ADDR_IDT2) begin
        tag_d[1] = sfr_wdata;
      end else if (sfr_addr == `CMAM_ADDR_IDT3) begin
        tag_d[2] = sfr_wdata;
      end else if (sfr_addr == `CMAM_ADDR_IDT4) begin
        tag_d[3] = sfr_wdata;
      end else if (sfr_addr == `CMAM_ADDR_IDM1) begin
        mask_d[0] = sfr_wdata;
      end else if (sfr_addr == `CMAM_ADDR_IDM2) begin
        mask_d[1] = sfr_wdata;
      end else if (sfr_addr == `CMAM_ADDR_IDM3) begin
        mask_d[2] = sfr_wdata;
      end else if (sfr_addr == `CMAM_ADDR_IDM4) begin
        mask_d[3] = sfr_wdata;
      end
    end
  end

  // No reset: contents are undefined until software writes them
  always_ff @(posedge clock) begin
    tag_q <= tag_d;
    mask_q <= mask_d;
  end

  // Mailbox index: page load wins, else wrap-around auto-increment
  always_comb begin
    idx_d = idx_q;
    if (page_load) begin
      idx_d = page_index;
    end else if (auto_inc_en && (sfr_addr == `CMAM_ADDR_MSG)
                 && (sfr_rd || sfr_wr)) begin
      idx_d = idx_q + 3'h1;
    end
  end

  // Mailbox array; core writes take priority over receive fills
  always_comb begin
    mbox_d = mbox_q;
    if (mbox_wr) begin
      mbox_d[mbox_addr(mbox_wobj, mbox_windex)] = mbox_wdata;
    end
    if (sfr_wr && (sfr_addr == `CMAM_ADDR_MSG)) begin
      mbox_d[mbox_addr(page_obj, idx_q)] = sfr_wdata;
    end
  end

  always_ff @(posedge clock) begin
    mbox_q <= mbox_d;
  end

  // Prescaler and message timer: timer steps once per presc+1 ticks
  always_comb begin
    presc_d = presc_q;
    pcnt_d = pcnt_q;
    timer_d = timer_q;
    if (sfr_wr && (sfr_addr == `CMAM_ADDR_PRESCALE)) begin
      presc_d = sfr_wdata;
    end
    if (timer_clk_tick) begin
      if (pcnt_q >= presc_q) begin
        pcnt_d = 8'h00;
        timer_d = timer_q + 16'h0001;
      end else begin
        pcnt_d = pcnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      presc_q <= `CMAM_PRESC_RST;
      pcnt_q <= 8'h00;
      timer_q <= `CMAM_TIMER_RST;
      idx_q <= `CMAM_PTR_RST;
    end else begin
      presc_q <= presc_d;
      pcnt_q <= pcnt_d;
      timer_q <= timer_d;
      idx_q <= idx_d;
    end
  end

  // Acceptance filter overview:
  //   Standard objects compare identifier bits 10..0 only; upper
  //   positions are masked off, so the unused tag bits never matter.
  //   Extended objects compare all 29 identifier bits.
  //   The remote-request bit is compared against the tag byte, the
  //   extension bit against the object's own format, each under its
  //   own mask bit in byte four.
  //   A cleared mask bit forces that position to match, which lets
  //   one object accept a whole range of identifiers.
  // The hit is registered, so it stands for exactly one cycle after
  // the check strobe; the receive engine must sample it then.
  // Trade-off: the 29-bit compare is one wide AND tree; registering
  // the hit keeps it off the receive engine's critical path.
  // Acceptance filter; transmit paths never see the mask
  always_comb begin
    logic ok;
    logic [28:0] mk;
    logic [28:0] tg;
    ok = 1'b1;
    mk = 29'h0;
    tg = 29'h0;
    if (obj_ext) begin
      mk = {mask_q[0], mask_q[1], mask_q[2], mask_q[3][7:3]};
      tg = {tag_q[0], tag_q[1], tag_q[2], tag_q[3][7:3]};
    end else begin
      mk = {18'h0, mask_q[0], mask_q[1][7:5]};
      tg = {18'h0, tag_q[0], tag_q[1][7:5]};
    end
    for (int i = 0; i < 29; i++) begin
      ok = ok && bit_ok(mk[i], tg[i], rx_ident[i]);
    end
    ok = ok && bit_ok(mask_q[3][`CMAM_B4_RTR],
                      tag_q[3][`CMAM_B4_RTR], rx_rtr);
    ok = ok && bit_ok(mask_q[3][`CMAM_B4_IDE],
                      obj_ext, rx_ext);
    hit_d = rx_check && obj_rx_en && ok;
  end

  // Read mux; reserved bits return stored contents, undefined to software
  always_comb begin
    rdata_d = 8'h00;
    if (sfr_addr == `CMAM_ADDR_PRESCALE) begin
      rdata_d = presc_q;
    end else if (sfr_addr == `CMAM_ADDR_MSG) begin
      rdata_d = page_load ? mbox_q[mbox_addr(page_obj, page_index)]
                          : mbox_q[mbox_addr(page_obj, idx_q)];
    end else if (sfr_addr == `CMAM_ADDR_TIML) begin
      rdata_d = timer_q[7:0];
    end else if (sfr_addr == `CMAM_ADDR_TIMH) begin
      rdata_d = timer_q[15:8];
    end else if (sfr_addr == `CMAM_ADDR_IDT1) begin
      rdata_d = tag_q[0];
    end else if (sfr_addr == `CMAM_ADDR_IDT2) begin
      rdata_d = tag_q[1];
    end else if (sfr_addr == `CMAM_ADDR_IDT3) begin
      rdata_d = tag_q[2];
    end else if (sfr_addr == `CMAM_ADDR_IDT4) begin
      rdata_d = tag_q[3];
    end else if (sfr_addr == `CMAM_ADDR_IDM1) begin
      rdata_d = mask_q[0];
    end else if (sfr_addr == `CMAM_ADDR_IDM2) begin
      rdata_d = mask_q[1];
    end else if (sfr_addr == `CMAM_ADDR_IDM3) begin
      rdata_d = mask_q[2];
    end else if (sfr_addr == `CMAM_ADDR_IDM4) begin
      rdata_d = mask_q[3];
    end
  end

  // Outputs registered so the core sees a stable byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hit_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      hit_q <= hit_d;
      rdata_q <= rdata_d;
    end
  end

  assign rx_hit = hit_q;
  assign sfr_rdata = rdata_q;
  assign message_timer_count = timer_q;

endmodule // cmam_core
`default_nettype wire

// *** pkg/cmam_defs.svh ***
// Register offsets, field positions and reset values for the CAN
// message-object mask, mailbox window and message timer block.
// Assumes an 8-bit SFR address space seen by the on-chip core.
`ifndef CMAM_DEFS_SVH
`define CMAM_DEFS_SVH

// SFR addresses
`define CMAM_ADDR_PRESCALE 8'ha1
`define CMAM_ADDR_MSG 8'ha3
`define CMAM_ADDR_TIML 8'hac
`define CMAM_ADDR_TIMH 8'had
`define CMAM_ADDR_IDT1 8'hbc
`define CMAM_ADDR_IDT2 8'hbd
`define CMAM_ADDR_IDT3 8'hbe
`define CMAM_ADDR_IDT4 8'hbf
`define CMAM_ADDR_IDM1 8'hc4
`define CMAM_ADDR_IDM2 8'hc5
`define CMAM_ADDR_IDM3 8'hc6
`define CMAM_ADDR_IDM4 8'hc7

// Fields of the fourth tag and mask registers
`define CMAM_B4_RTR 2
`define CMAM_B4_RB1 1
`define CMAM_B4_IDE 0

// Reset values
`define CMAM_TIMER_RST 16'h0000
`define CMAM_PRESC_RST 8'h00
`define CMAM_PTR_RST 3'h0

`endif

// *** pkg/cmam_pkg.sv ***
// Types shared by the mask and mailbox block.
// Assumes the defines header is compiled alongside.
package cmam_pkg;
  typedef logic [7:0] cmam_byte_t;
  typedef logic [28:0] cmam_ident_t;
endpackage
